/* File: shared/rsras_pkg.sv */
package rsras_pkg;
  // Channel and rank organisation
  localparam int NUM_CH = 3;
  localparam int CH_W = 2;
  localparam int DIMMS = 2;
  localparam int RANKS = 8;
  localparam int RANK_W = 3;
  localparam int RCNT_W = 4;
  localparam logic [RCNT_W-1:0] MAX_LOG_RANKS = 4'h8;
  localparam logic [2:0] QUAD_RANKS = 3'h4;
  localparam logic [2:0] DUAL_RANKS = 3'h2;
  localparam logic [1:0] MIN_SPARE_DIMMS = 2'h2;
  // Error counting
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  // Rank size code: lines in a rank = 2**code
  localparam int SIZE_W = 5;
  localparam int IDX_W = 32;
  // Frequency and timing
  localparam int SPD_W = 3;
  localparam logic [SPD_W-1:0] SPD_TOP = 3'h7;
  localparam int TIM_N = 4;
  localparam int TIM_W = 6;
  // Independent channel burst
  localparam int LINE_BYTES = 64;
  localparam int BEAT_BYTES = 8;
  localparam int BEATS = LINE_BYTES / BEAT_BYTES;
  localparam int BEAT_BITS = BEAT_BYTES * 8;
  localparam int LINE_BITS = LINE_BYTES * 8;
  localparam logic [2:0] BEAT_LAST = 3'h7;

  typedef enum logic [1:0] {
    RSRAS_MODE_INDEP,
    RSRAS_MODE_MIRROR,
    RSRAS_MODE_LOCKSTEP
  } rsras_mode_t;

  typedef enum logic [1:0] {
    SP_NORMAL,
    SP_COPY,
    SP_DONE
  } rsras_sp_state_t;

  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] ch;
    logic [RANK_W-1:0] rank;
  } rsras_ce_t;

  typedef struct packed {
    logic start;
    logic done;
    logic [CH_W-1:0] ch;
    logic [RANK_W-1:0] rank;
  } rsras_fo_t;

  typedef struct packed {
    logic valid;
    logic [RANK_W-1:0] src;
    logic [RANK_W-1:0] dst;
    logic [IDX_W-1:0] line;
  } rsras_copy_t;

  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] ch;
    logic [RANK_W-1:0] rank;
  } rsras_xlat_t;
endpackage

/* File: rtl/rsras_rank_cnt.sv */
`timescale 1ns/10ps
`default_nettype none
module rsras_rank_cnt (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic inc,
  input wire logic [rsras_pkg::CNT_W-1:0] threshold,
  // Status
  output logic hit
);
  logic [rsras_pkg::CNT_W-1:0] cnt_r;
  logic [rsras_pkg::CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = '0;
    end else if (inc && cnt_r != rsras_pkg::CNT_MAX) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Zero threshold means counting never fails a rank
  assign hit = (threshold != '0) && (cnt_r >= threshold);
endmodule // rsras_rank_cnt
`default_nettype wire

/* File: rtl/rsras_burst.sv */
`timescale 1ns/10ps
`default_nettype none
module rsras_burst (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Cache line in
  input wire logic line_valid,
  output logic line_ready,
  input wire logic [rsras_pkg::LINE_BITS-1:0] line_data,
  // Beats out
  output logic beat_valid,
  output logic [rsras_pkg::BEAT_BITS-1:0] beat_data,
  output logic beat_last
);
  logic [rsras_pkg::LINE_BITS-1:0] shift_r;
  logic [rsras_pkg::LINE_BITS-1:0] shift_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;

  assign beat_last = busy_r && (cnt_r == rsras_pkg::BEAT_LAST);
  // Next line loads on the last beat, so bursts abut
  assign line_ready = !busy_r || beat_last;

  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (line_valid && line_ready) begin
      shift_nxt = line_data;
      cnt_nxt = '0;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      shift_nxt = shift_r >> rsras_pkg::BEAT_BITS;
      cnt_nxt = cnt_r + 3'h1;
      busy_nxt = !beat_last;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign beat_valid = busy_r;
  assign beat_data = shift_r[rsras_pkg::BEAT_BITS-1:0];
endmodule // rsras_burst
`default_nettype wire

/* File: rtl/rsras_top.sv */
// How it works
// - The spare rank is hidden from host address translation while sparing runs.
// - Each channel reserves its largest populated rank as spare.
// - After failover the source rank stays disabled until the next cfg_load.
// - Every channel has its own spare, counters and failover state.
// - Sparing offered only with two 1/2-rank DIMMs or one quad per channel.
// - One correctable-error counter per rank per channel, compared to threshold.
// - A rank other than the spare reaching threshold is failing and starts failover on its channel.
// - Failover copies every line of the failing rank, then remaps it to spare.
// - After failover the channel ignores further correctable errors.
// - Other redundant channels keep counting; one failover per channel.
// - Only the first correctable error in the system is reported.
// - A channel delivers each 64-byte line as eight 8-byte beats.
// - Same-direction same-rank transfers follow with no idle cycle.
// - All modules run at the lowest common rated frequency.
// - Each channel uses the slowest timings of its modules.
// - At most 8 host-visible logical ranks per channel.
// - Mirror or lockstep only with ECC modules; else independent mode.
// - Registered modules force single-cycle command timing.
`timescale 1ns/10ps
`default_nettype none
module rsras_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration from init code
  input wire logic cfg_load,
  input wire logic spare_en,
  input wire rsras_pkg::rsras_mode_t mode_req,
  input wire logic ecc_all,
  input wire logic registered,
  input wire logic [rsras_pkg::CNT_W-1:0] ce_threshold,
  input wire logic [2:0] dimm_ranks [rsras_pkg::NUM_CH][rsras_pkg::DIMMS],
  input wire logic [rsras_pkg::SPD_W-1:0]
    dimm_speed [rsras_pkg::NUM_CH][rsras_pkg::DIMMS],
  input wire logic [rsras_pkg::TIM_N*rsras_pkg::TIM_W-1:0]
    dimm_timing [rsras_pkg::NUM_CH][rsras_pkg::DIMMS],
  input wire logic [rsras_pkg::SIZE_W-1:0]
    rank_size [rsras_pkg::NUM_CH][rsras_pkg::RANKS],
  // Configuration results
  output logic sparing_allowed,
  output logic sparing_active,
  output rsras_pkg::rsras_mode_t eff_mode,
  output logic [rsras_pkg::SPD_W-1:0] run_speed,
  output logic [rsras_pkg::TIM_N*rsras_pkg::TIM_W-1:0]
    ch_timing [rsras_pkg::NUM_CH],
  output logic single_cycle_command_timing,
  output logic cfg_rank_err,
  output logic [rsras_pkg::RANK_W-1:0] spare_rank [rsras_pkg::NUM_CH],
  // Correctable errors
  input wire rsras_pkg::rsras_ce_t ce_in,
  output rsras_pkg::rsras_ce_t ce_report,
  // Failover status
  output rsras_pkg::rsras_fo_t sparing_failover_event,
  output logic [rsras_pkg::NUM_CH-1:0] ch_redundant,
  output logic [rsras_pkg::RANKS-1:0] rank_disabled [rsras_pkg::NUM_CH],
  // Copy requests to the data path
  output rsras_pkg::rsras_copy_t copy_req [rsras_pkg::NUM_CH],
  input wire logic [rsras_pkg::NUM_CH-1:0] copy_ready,
  // Host rank translation
  input wire rsras_pkg::rsras_xlat_t xlat_in,
  output rsras_pkg::rsras_xlat_t xlat_out,
  output logic xlat_reject,
  // Independent channel bursts
  input wire logic [rsras_pkg::NUM_CH-1:0] line_valid,
  output logic [rsras_pkg::NUM_CH-1:0] line_ready,
  input wire logic [rsras_pkg::LINE_BITS-1:0] line_data [rsras_pkg::NUM_CH],
  output logic [rsras_pkg::NUM_CH-1:0] beat_valid,
  output logic [rsras_pkg::BEAT_BITS-1:0] beat_data [rsras_pkg::NUM_CH],
  output logic [rsras_pkg::NUM_CH-1:0] beat_last
);
  localparam int NC = rsras_pkg::NUM_CH;
  localparam int NR = rsras_pkg::RANKS;
  localparam int RW = rsras_pkg::RANK_W;
  localparam int TW = rsras_pkg::TIM_W;
  localparam int RCNT_W = rsras_pkg::RCNT_W;
  localparam int CH_W = rsras_pkg::CH_W;

  // Configuration state
  logic allowed_r, allowed_nxt;
  logic active_r, active_nxt;
  rsras_pkg::rsras_mode_t mode_r, mode_nxt;
  logic [rsras_pkg::SPD_W-1:0] speed_r, speed_nxt;
  logic [rsras_pkg::TIM_N*TW-1:0] tim_r [NC];
  logic [rsras_pkg::TIM_N*TW-1:0] tim_nxt [NC];
  logic cmd1_r, cmd1_nxt;
  logic rerr_r, rerr_nxt;
  logic [RW-1:0] spare_r [NC];
  logic [RW-1:0] spare_nxt [NC];
  logic [NR-1:0] pop_r [NC];
  logic [NR-1:0] pop_nxt [NC];
  logic [rsras_pkg::SIZE_W-1:0] size_r [NC][NR];
  logic [rsras_pkg::SIZE_W-1:0] size_nxt [NC][NR];

  always_comb begin
    logic [rsras_pkg::RCNT_W-1:0] nrk;
    logic [1:0] small_dimms;
    logic quad;
    logic ok;
    logic ecc_mode;
    nrk = '0;
    small_dimms = '0;
    quad = 1'b0;
    ok = 1'b1;
    ecc_mode = 1'b0;
    allowed_nxt = allowed_r;
    active_nxt = active_r;
    mode_nxt = mode_r;
    speed_nxt = speed_r;
    cmd1_nxt = cmd1_r;
    rerr_nxt = rerr_r;
    tim_nxt = tim_r;
    spare_nxt = spare_r;
    pop_nxt = pop_r;
    size_nxt = size_r;
    if (cfg_load) begin
      rerr_nxt = 1'b0;
      speed_nxt = rsras_pkg::SPD_TOP;
      for (int c = 0; c < NC; c++) begin
        nrk = '0;
        small_dimms = '0;
        quad = 1'b0;
        tim_nxt[c] = '0;
        for (int d = 0; d < rsras_pkg::DIMMS; d++) begin
          nrk = nrk + {1'b0, dimm_ranks[c][d]};
          if (dimm_ranks[c][d] == rsras_pkg::QUAD_RANKS) begin
            quad = 1'b1;
          end
          if (dimm_ranks[c][d] != '0 &&
              dimm_ranks[c][d] <= rsras_pkg::DUAL_RANKS) begin
            small_dimms = small_dimms + 2'h1;
          end
          if (dimm_ranks[c][d] != '0) begin
            if (dimm_speed[c][d] < speed_nxt) begin
              speed_nxt = dimm_speed[c][d];
            end
            for (int t = 0; t < rsras_pkg::TIM_N; t++) begin
              if (dimm_timing[c][d][t*TW +: TW] > tim_nxt[c][t*TW +: TW]) begin
                tim_nxt[c][t*TW +: TW] = dimm_timing[c][d][t*TW +: TW];
              end
            end
          end
        end
        if (nrk > rsras_pkg::MAX_LOG_RANKS) begin
          rerr_nxt = 1'b1;
        end
        if (!(quad || small_dimms >= rsras_pkg::MIN_SPARE_DIMMS)) begin
          ok = 1'b0;
        end
        spare_nxt[c] = '0;
        for (int r = 0; r < NR; r++) begin
          pop_nxt[c][r] = (RCNT_W'(r) < nrk) && !rerr_nxt;
          size_nxt[c][r] = rank_size[c][r];
          if (pop_nxt[c][r] && rank_size[c][r] > rank_size[c][spare_nxt[c]]) begin
            spare_nxt[c] = RW'(r);
          end
        end
      end
      allowed_nxt = ok;
      active_nxt = spare_en && ok;
      ecc_mode = mode_req != rsras_pkg::RSRAS_MODE_INDEP;
      mode_nxt = (ecc_mode && !ecc_all) ? rsras_pkg::RSRAS_MODE_INDEP
                                        : mode_req;
      cmd1_nxt = registered;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      allowed_r <= 1'b0;
      active_r <= 1'b0;
      mode_r <= rsras_pkg::RSRAS_MODE_INDEP;
      speed_r <= '0;
      cmd1_r <= 1'b0;
      rerr_r <= 1'b0;
      tim_r <= '{default: '0};
      spare_r <= '{default: '0};
      pop_r <= '{default: '0};
      size_r <= '{default: '0};
    end else begin
      allowed_r <= allowed_nxt;
      active_r <= active_nxt;
      mode_r <= mode_nxt;
      speed_r <= speed_nxt;
      cmd1_r <= cmd1_nxt;
      rerr_r <= rerr_nxt;
      tim_r <= tim_nxt;
      spare_r <= spare_nxt;
      pop_r <= pop_nxt;
      size_r <= size_nxt;
    end
  end

  // Per rank error counters
  logic [NR-1:0] hit [NC];
  rsras_pkg::rsras_sp_state_t st_r [NC];
  rsras_pkg::rsras_sp_state_t st_nxt [NC];

  for (genvar gc = 0; gc < NC; gc++) begin : g_ch
    for (genvar gr = 0; gr < NR; gr++) begin : g_rk
      logic inc;
      // Copying and done channels stop counting; normal ones keep going
      assign inc = ce_in.valid && ce_in.ch == CH_W'(gc) &&
                   ce_in.rank == RW'(gr) && pop_r[gc][gr] &&
                   st_r[gc] == rsras_pkg::SP_NORMAL;
      rsras_rank_cnt u_cnt (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(cfg_load),
        .inc(inc),
        .threshold(ce_threshold),
        .hit(hit[gc][gr])
      );
    end
    rsras_burst u_burst (
      .clk_sys(clk_sys),
      .rst(rst),
      .line_valid(line_valid[gc]),
      .line_ready(line_ready[gc]),
      .line_data(line_data[gc]),
      .beat_valid(beat_valid[gc]),
      .beat_data(beat_data[gc]),
      .beat_last(beat_last[gc])
    );
  end

  // Failover state per channel
  logic [RW-1:0] src_r [NC];
  logic [RW-1:0] src_nxt [NC];
  logic [rsras_pkg::IDX_W-1:0] idx_r [NC];
  logic [rsras_pkg::IDX_W-1:0] idx_nxt [NC];
  logic [NR-1:0] dis_r [NC];
  logic [NR-1:0] dis_nxt [NC];
  rsras_pkg::rsras_fo_t fo_r, fo_nxt;

  always_comb begin
    logic [rsras_pkg::IDX_W-1:0] last;
    logic found;
    last = '0;
    found = 1'b0;
    st_nxt = st_r;
    src_nxt = src_r;
    idx_nxt = idx_r;
    dis_nxt = dis_r;
    fo_nxt = '0;
    for (int c = 0; c < NC; c++) begin
      found = 1'b0;
      last = (rsras_pkg::IDX_W'(1) << size_r[c][src_r[c]]) -
             rsras_pkg::IDX_W'(1);
      unique case (st_r[c])
        rsras_pkg::SP_NORMAL: begin
          for (int r = 0; r < NR; r++) begin
            if (!found && active_r && hit[c][r] && RW'(r) != spare_r[c]) begin
              found = 1'b1;
              src_nxt[c] = RW'(r);
            end
          end
          if (found) begin
            st_nxt[c] = rsras_pkg::SP_COPY;
            idx_nxt[c] = '0;
            fo_nxt.start = 1'b1;
            fo_nxt.ch = CH_W'(c);
            fo_nxt.rank = src_nxt[c];
          end
        end
        rsras_pkg::SP_COPY: begin
          if (copy_ready[c]) begin
            if (idx_r[c] == last) begin
              st_nxt[c] = rsras_pkg::SP_DONE;
              dis_nxt[c][src_r[c]] = 1'b1;
              fo_nxt.done = 1'b1;
              fo_nxt.ch = CH_W'(c);
              fo_nxt.rank = src_r[c];
            end else begin
              idx_nxt[c] = idx_r[c] + rsras_pkg::IDX_W'(1);
            end
          end
        end
        rsras_pkg::SP_DONE: begin
          st_nxt[c] = rsras_pkg::SP_DONE;
        end
      endcase
      if (cfg_load) begin
        st_nxt[c] = rsras_pkg::SP_NORMAL;
        dis_nxt[c] = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '{default: rsras_pkg::SP_NORMAL};
      src_r <= '{default: '0};
      idx_r <= '{default: '0};
      dis_r <= '{default: '0};
      fo_r <= '0;
    end else begin
      st_r <= st_nxt;
      src_r <= src_nxt;
      idx_r <= idx_nxt;
      dis_r <= dis_nxt;
      fo_r <= fo_nxt;
    end
  end

  // First correctable error in the system, reported for one cycle; seen flag kept until reset
  logic seen_r, seen_nxt;
  rsras_pkg::rsras_ce_t rep_r, rep_nxt;

  always_comb begin
    seen_nxt = seen_r || ce_in.valid;
    rep_nxt = '0;
    if (ce_in.valid && !seen_r) begin
      rep_nxt = ce_in;
    end
  end

  // Host rank translation
  rsras_pkg::rsras_xlat_t xo_r, xo_nxt;
  logic rej_r, rej_nxt;

  always_comb begin
    xo_nxt = xlat_in;
    rej_nxt = 1'b0;
    if (xlat_in.valid) begin
      if (!pop_r[xlat_in.ch][xlat_in.rank]) begin
        rej_nxt = 1'b1;
      end else if (active_r && xlat_in.rank == spare_r[xlat_in.ch] &&
                   st_r[xlat_in.ch] != rsras_pkg::SP_DONE) begin
        rej_nxt = 1'b1;
      end else if (dis_r[xlat_in.ch][xlat_in.rank]) begin
        xo_nxt.rank = spare_r[xlat_in.ch];
      end
    end
    if (rej_nxt) begin
      xo_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen_r <= 1'b0;
      rep_r <= '0;
      xo_r <= '0;
      rej_r <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
      rep_r <= rep_nxt;
      xo_r <= xo_nxt;
      rej_r <= rej_nxt;
    end
  end

  // Outputs
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      copy_req[c].valid = st_r[c] == rsras_pkg::SP_COPY;
      copy_req[c].src = src_r[c];
      copy_req[c].dst = spare_r[c];
      copy_req[c].line = idx_r[c];
      ch_redundant[c] = active_r && st_r[c] != rsras_pkg::SP_DONE;
    end
  end

  assign sparing_allowed = allowed_r;
  assign sparing_active = active_r;
  assign eff_mode = mode_r;
  assign run_speed = speed_r;
  assign ch_timing = tim_r;
  assign single_cycle_command_timing = cmd1_r;
  assign cfg_rank_err = rerr_r;
  assign spare_rank = spare_r;
  assign ce_report = rep_r;
  assign sparing_failover_event = fo_r;
  assign rank_disabled = dis_r;
  assign xlat_out = xo_r;
  assign xlat_reject = rej_r;
endmodule // rsras_top
`default_nettype wire

/* File: testbench/rsras_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module rsras_top_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic cfg_load,
  input wire logic registered,
  input wire logic single_cycle_command_timing,
  input wire logic sparing_active,
  input wire logic [rsras_pkg::RANK_W-1:0] spare_rank [rsras_pkg::NUM_CH],
  // Errors and failover
  input wire rsras_pkg::rsras_ce_t ce_in,
  input wire rsras_pkg::rsras_ce_t ce_report,
  input wire rsras_pkg::rsras_fo_t sparing_failover_event,
  input wire logic [rsras_pkg::NUM_CH-1:0] ch_redundant,
  input wire logic [rsras_pkg::RANKS-1:0] rank_disabled [rsras_pkg::NUM_CH],
  input wire rsras_pkg::rsras_copy_t copy_req [rsras_pkg::NUM_CH],
  input wire rsras_pkg::rsras_xlat_t xlat_out,
  // Bursts
  input wire logic [rsras_pkg::NUM_CH-1:0] line_valid,
  input wire logic [rsras_pkg::NUM_CH-1:0] line_ready,
  input wire logic [rsras_pkg::NUM_CH-1:0] beat_valid,
  input wire logic [rsras_pkg::NUM_CH-1:0] beat_last
);
  logic seen_r;
  logic seen_nxt;
  always_comb seen_nxt = seen_r | ce_report.valid;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) seen_r <= 1'b0;
    else seen_r <= seen_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_report_only_first: assert property (ce_report.valid |-> !seen_r)
    else $error("second correctable error reported");
  a_report_has_cause: assert property (ce_report.valid |-> $past(ce_in.valid))
    else $error("error report without a correctable error");
  a_start_when_redundant: assert property (sparing_failover_event.start |->
    sparing_active && ch_redundant[sparing_failover_event.ch])
    else $error("failover started on a channel without redundancy");
  a_done_disables_src: assert property (sparing_failover_event.done |->
    rank_disabled[sparing_failover_event.ch][sparing_failover_event.rank])
    else $error("source rank still enabled after failover");
  a_copy_into_spare: assert property (copy_req[0].valid |->
    copy_req[0].dst == spare_rank[0] && copy_req[0].src != copy_req[0].dst)
    else $error("copy does not target the spare rank");
  a_xlat_hides_spare: assert property (xlat_out.valid && sparing_active &&
    ch_redundant[xlat_out.ch] |-> xlat_out.rank != spare_rank[xlat_out.ch])
    else $error("spare rank handed to the host");
  a_cmd_timing_cfg: assert property ($past(cfg_load) |->
    single_cycle_command_timing == $past(registered))
    else $error("command timing does not follow module type");
  a_burst_eight_beats: assert property (line_valid[0] && line_ready[0] |->
    ##8 beat_valid[0] && beat_last[0])
    else $error("line not delivered as eight beats");
  a_burst_no_gap: assert property (line_valid[0] && line_ready[0] |=>
    beat_valid[0] [*8])
    else $error("idle cycle inside or before a burst");
endmodule // rsras_top_props
bind rsras_top rsras_top_props u_props (.clk_sys, .rst, .cfg_load,
  .registered, .single_cycle_command_timing, .sparing_active, .spare_rank,
  .ce_in, .ce_report, .sparing_failover_event, .ch_redundant, .rank_disabled,
  .copy_req, .xlat_out, .line_valid, .line_ready, .beat_valid, .beat_last);
`default_nettype wire

/* File: testbench/rsras_copy_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module rsras_copy_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Copy handshake
  input wire rsras_pkg::rsras_copy_t copy_req [rsras_pkg::NUM_CH],
  input wire logic slow,
  output logic [rsras_pkg::NUM_CH-1:0] copy_ready,
  // Observation
  output logic [7:0] accepts [rsras_pkg::NUM_CH],
  output logic seq_err
);
  // Slow mode stalls every other cycle, as a busy rank would
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      copy_ready <= 3'h0;
      accepts <= '{default: 8'h00};
      seq_err <= 1'b0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (copy_req[c].valid && copy_ready[c]) begin
          if (copy_req[c].line !== 32'(accepts[c])) seq_err <= 1'b1;
          accepts[c] <= accepts[c] + 8'h01;
        end
        copy_ready[c] <= slow ? ~copy_ready[c] : 1'b1;
      end
    end
  end
endmodule // rsras_copy_sink
`default_nettype wire

/* File: testbench/test_rsras_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_rsras_top;
  logic clk_sys, rst, cfg_load, spare_en, ecc_all, registered, slow, seq_err;
  logic sparing_allowed, sparing_active, single_cycle_command_timing;
  logic cfg_rank_err, xlat_reject;
  rsras_pkg::rsras_mode_t mode_req, eff_mode;
  logic [7:0] ce_threshold;
  logic [2:0] dimm_ranks [3][2];
  logic [2:0] dimm_speed [3][2];
  logic [23:0] dimm_timing [3][2];
  logic [4:0] rank_size [3][8];
  logic [2:0] run_speed, ch_redundant, copy_ready, line_valid, line_ready;
  logic [2:0] beat_valid, beat_last;
  logic [23:0] ch_timing [3];
  logic [2:0] spare_rank [3];
  logic [7:0] rank_disabled [3];
  logic [7:0] accepts [3];
  rsras_pkg::rsras_ce_t ce_in, ce_report;
  rsras_pkg::rsras_fo_t sparing_failover_event;
  rsras_pkg::rsras_copy_t copy_req [3];
  rsras_pkg::rsras_xlat_t xlat_in, xlat_out;
  logic [511:0] line_data [3];
  logic [63:0] beat_data [3];
  int fail_count, checked, cyc;

  rsras_top dut_u (.clk_sys, .rst, .cfg_load, .spare_en, .mode_req, .ecc_all,
    .registered, .ce_threshold, .dimm_ranks, .dimm_speed, .dimm_timing,
    .rank_size, .sparing_allowed, .sparing_active, .eff_mode, .run_speed,
    .ch_timing, .single_cycle_command_timing, .cfg_rank_err, .spare_rank,
    .ce_in, .ce_report, .sparing_failover_event, .ch_redundant,
    .rank_disabled, .copy_req, .copy_ready, .xlat_in, .xlat_out, .xlat_reject,
    .line_valid, .line_ready, .line_data, .beat_valid, .beat_data, .beat_last);
  rsras_copy_sink sink_u (.clk_sys, .rst, .copy_req, .slow, .copy_ready,
    .accepts, .seq_err);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task check(input string name, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Bound on tests of under a hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task step;
    @(posedge clk_sys) #1;
  endtask

  task cfg;
    cfg_load = 1'b1;
    step();
    cfg_load = 1'b0;
  endtask

  task ce(input logic [1:0] ch, input logic [2:0] rk);
    ce_in = '{1'b1, ch, rk};
    step();
    ce_in = '0;
  endtask

  task xl(input logic [1:0] ch, input logic [2:0] rk, input logic rej,
    input logic [2:0] er);
    xlat_in = '{1'b1, ch, rk};
    step();
    xlat_in = '0;
    check("xlat_reject", xlat_reject, rej);
    if (!rej) check("xlat_rank", xlat_out.rank, er);
  endtask

  task wait_fo(input bit for_done);
    int i;
    for (i = 0; i < 80; i++) begin
      step();
      if (for_done ? sparing_failover_event.done
          : sparing_failover_event.start) break;
    end
    check("failover_seen", i < 80, 1);
  endtask

  task t_config;
    cfg();
    check("sparing_allowed", sparing_allowed, 1);
    check("sparing_active", sparing_active, 1);
    check("eff_mode", eff_mode, rsras_pkg::RSRAS_MODE_INDEP);
    check("run_speed", run_speed, 3'h3);
    check("ch_timing", ch_timing[0], 24'h109143);
    check("cmd_timing", single_cycle_command_timing, 1);
    check("rank_err", cfg_rank_err, 0);
    check("spare0", spare_rank[0], 3'h2);
    check("spare1", spare_rank[1], 3'h1);
    check("spare2", spare_rank[2], 3'h3);
    ecc_all = 1'b1;
    registered = 1'b0;
    dimm_ranks[1] = '{3'h1, 3'h0};
    cfg();
    check("eff_mode", eff_mode, rsras_pkg::RSRAS_MODE_MIRROR);
    check("cmd_timing", single_cycle_command_timing, 0);
    check("sparing_allowed", sparing_allowed, 0);
    dimm_ranks[1] = '{3'h2, 3'h1};
    dimm_ranks[2] = '{3'h7, 3'h4};
    mode_req = rsras_pkg::RSRAS_MODE_LOCKSTEP;
    cfg();
    check("rank_err", cfg_rank_err, 1);
    check("eff_mode", eff_mode, rsras_pkg::RSRAS_MODE_LOCKSTEP);
    dimm_ranks[2] = '{3'h4, 3'h4};
    mode_req = rsras_pkg::RSRAS_MODE_INDEP;
    cfg();
    $display("config test done");
  endtask

  task t_failover;
    xl(2'h0, 3'h2, 1, 3'h0);
    xl(2'h0, 3'h1, 0, 3'h1);
    xl(2'h0, 3'h5, 1, 3'h0);
    ce(2'h0, 3'h0);
    check("ce_report", ce_report.valid, 1);
    check("ce_report_rank", ce_report.rank, 3'h0);
    ce(2'h0, 3'h0);
    check("ce_report", ce_report.valid, 0);
    repeat (3) begin
      step();
      check("early_start", sparing_failover_event.start, 0);
    end
    ce(2'h0, 3'h0);
    wait_fo(0);
    check("start_ch", sparing_failover_event.ch, 2'h0);
    check("start_rank", sparing_failover_event.rank, 3'h0);
    wait_fo(1);
    check("done_rank", sparing_failover_event.rank, 3'h0);
    check("disabled0", rank_disabled[0], 8'h01);
    check("copied0", accepts[0], 8'h08);
    check("copy_order", seq_err, 0);
    check("redundant", ch_redundant, 3'h6);
    xl(2'h0, 3'h0, 0, 3'h2);
    repeat (3) ce(2'h0, 3'h1);
    repeat (5) begin
      step();
      check("refail", sparing_failover_event.start, 0);
    end
    slow = 1'b0;
    repeat (3) ce(2'h1, 3'h0);
    wait_fo(0);
    check("start_ch", sparing_failover_event.ch, 2'h1);
    wait_fo(1);
    check("disabled1", rank_disabled[1], 8'h01);
    check("copied1", accepts[1], 8'h08);
    $display("failover test done");
  endtask

  function automatic logic [511:0] mk(input int n);
    logic [511:0] v;
    for (int i = 0; i < 8; i++) v[i*64 +: 64] = 64'(n * 16 + i + 1);
    return v;
  endfunction

  task t_burst;
    line_data[0] = mk(0);
    line_valid[0] = 1'b1;
    for (int k = 0; k < 16; k++) begin
      step();
      if (k == 0) line_data[0] = mk(1);
      if (k == 8) line_valid[0] = 1'b0;
      check("beat_valid", beat_valid[0], 1);
      check("beat_data", beat_data[0], 64'(k / 8 * 16 + k % 8 + 1));
      check("beat_last", beat_last[0], k % 8 == 7);
    end
    step();
    check("beat_idle", beat_valid[0], 0);
    $display("burst test done");
  endtask

  initial begin
    rst = 1'b1;
    cfg_load = 1'b0;
    spare_en = 1'b1;
    ecc_all = 1'b0;
    registered = 1'b1;
    slow = 1'b1;
    mode_req = rsras_pkg::RSRAS_MODE_MIRROR;
    ce_threshold = 8'h03;
    ce_in = '0;
    xlat_in = '0;
    line_valid = 3'h0;
    line_data = '{default: '0};
    dimm_ranks = '{default: '{3'h2, 3'h1}};
    dimm_ranks[2] = '{3'h4, 3'h4};
    dimm_speed = '{default: '{3'h7, 3'h7}};
    dimm_speed[0] = '{3'h5, 3'h3};
    dimm_timing = '{default: '{24'h000000, 24'h000000}};
    dimm_timing[0] = '{{6'h01, 6'h09, 6'h02, 6'h03},
                       {6'h04, 6'h02, 6'h05, 6'h01}};
    rank_size = '{default: '{default: 5'h03}};
    rank_size[0][2] = 5'h04;
    rank_size[1][1] = 5'h05;
    rank_size[2][3] = 5'h04;
    rank_size[2][5] = 5'h04;
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_config();
    t_failover();
    t_burst();
    report_and_stop();
  end
endmodule // test_rsras_top
`default_nettype wire
